// *** swpm_monitor.sv ***
// Purpose: servo warning codes and protective trips
// Assumes: measurements arrive synchronous to i_sys_clk, scaled by upstream logic
// Notes: trips are sticky until alarm clear; warnings per independent slot
`timescale 1ns/100ps
`default_nettype none
// How it works
// (R01) Warnings assert below trip thresholds; non-latching ones follow their cause.
// (R02) Latchable warnings hold 1 to 10 s, or forever, after cause ends.
// (R03) Battery and lifetime warnings always latch without time limit.
// (R04) Alarm clear held active keeps every warning cleared.
// (R05) Overload warning when load factor is 85 percent or more.
// (R06) Regeneration warning when regenerative load is 85 percent or more.
// (R07) Battery warning when voltage is 3.2 V or lower.
// (R08) Fan warning after one second stopped, except during servo-off stop.
// (R09) Encoder warning when consecutive comm errors exceed the limit.
// (R10) Scale warning when consecutive comm errors exceed the limit.
// (R11) Encoder overheat report raises its warning.
// (R12) Scale alarm report raises its warning.
// (R13) Oscillation warning when vibration exceeds detect level.
// (R14) Lifetime warning when remaining life drops below the specified time.
// (R15) Over-speed trip above level; default max speed times 1.2.
// (R16) Deviation trip in position or full-closed modes above excess level.
// (R17) Deviation excess level defaults to 100000 command-unit pulses.
// (R18) Unit select 0 compares command deviation, 1 encoder or full-closed deviation.
// (R19) With unit select 1, filter and damping do not affect deviation.
// (R20) Working range trip when motor position exceeds allowed revolutions; the code trips only in position or full-closed mode with servo on.
// (R21) Hybrid deviation trip in full-closed mode; default 16000 pulses.
// (R22) Torque clamped to first limit; limiting output while clamping.
// (R23) Each warning slot has its own independent latch timer.
module swpm_monitor
    import swpm_pkg::*;
#(
    parameter int ERR_CNT_W = 8,
    parameter int FAN_STOP_CYCLES = FAN_STOP_CYC,
    parameter int SEC_CYCLES = TICK_CYC,
    parameter logic [31:0] DEV_EXCESS_INIT = DEV_EXCESS_DEFAULT,
    parameter logic [31:0] HYBRID_DEV_INIT = HYBRID_DEV_DEFAULT
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_alarm_clear_input,
    input wire logic [3:0] i_warning_latch_time,
    input wire logic i_servo_on,
    input wire ctrl_mode_type i_ctrl_mode,
    input wire logic [7:0] i_load_factor_pct,
    input wire logic [7:0] i_regen_factor_pct,
    input wire logic [15:0] i_battery_mv,
    input wire logic i_fan_stopped,
    input wire logic i_fan_servo_off_stop,
    input wire logic i_enc_comm_err,
    input wire logic i_enc_comm_ok,
    input wire logic [ERR_CNT_W-1:0] i_enc_err_limit,
    input wire logic i_scale_comm_err,
    input wire logic i_scale_comm_ok,
    input wire logic [ERR_CNT_W-1:0] i_scale_err_limit,
    input wire logic i_enc_overheat,
    input wire logic i_scale_alarm,
    input wire logic [15:0] i_vibration,
    input wire logic [15:0] i_oscillation_detect_level,
    input wire logic i_life_expired,
    input wire logic [15:0] i_motor_speed,
    input wire logic [15:0] i_motor_max_speed,
    input wire logic [15:0] i_overspeed_level,
    input wire logic [31:0] i_dev_cmd_unit,
    input wire logic [31:0] i_dev_enc_unit,
    input wire logic i_deviation_unit_select,
    input wire logic [31:0] i_deviation_excess_level,
    input wire logic [31:0] i_motor_pos_abs,
    input wire logic [31:0] i_working_range_setting,
    input wire logic [31:0] i_hybrid_dev,
    input wire logic [31:0] i_hybrid_deviation_level,
    input wire logic [15:0] i_torque_request,
    input wire logic [15:0] i_first_torque_limit,
    output logic [NUM_WARN-1:0] o_warnings,
    output logic o_trip_overspeed,
    output logic o_trip_deviation,
    output logic o_trip_range,
    output logic o_trip_hybrid,
    output logic [15:0] o_torque_cmd,
    output logic o_torque_limiting_output
);
    function automatic logic over_limit(input logic [ERR_CNT_W-1:0] cnt, input logic [ERR_CNT_W-1:0] lim);
        over_limit = cnt > lim;
    endfunction

    logic [NUM_WARN-1:0] cause;
    logic [NUM_WARN-1:0] active;
    logic [$clog2(SEC_CYCLES+1)-1:0] sec_cnt;
    logic sec_tick;
    logic [$clog2(FAN_STOP_CYCLES+1)-1:0] fan_cnt;
    logic [ERR_CNT_W-1:0] enc_errs;
    logic [ERR_CNT_W-1:0] scale_errs;

    // One-second enable for the latch timers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || sec_cnt == ($bits(sec_cnt))'(SEC_CYCLES - 1)) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_cnt + 1'b1;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= sec_cnt == ($bits(sec_cnt))'(SEC_CYCLES - 1);
        end
    end

    // Fan timer ignores the deliberate stop taken while servo is off
    wire fan_fault = i_fan_stopped && !(i_fan_servo_off_stop && !i_servo_on); // [R08]
    wire fan_done = fan_cnt == ($bits(fan_cnt))'(FAN_STOP_CYCLES);
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !fan_fault) begin
            fan_cnt <= '0;
        end else if (!fan_done) begin
            fan_cnt <= fan_cnt + 1'b1; // [R08]
        end
    end

    // Consecutive error counts saturate and restart on a good frame
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_enc_comm_ok) begin
            enc_errs <= '0;
        end else if (i_enc_comm_err && enc_errs != '1) begin
            enc_errs <= enc_errs + 1'b1; // [R09]
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_scale_comm_ok) begin
            scale_errs <= '0;
        end else if (i_scale_comm_err && scale_errs != '1) begin
            scale_errs <= scale_errs + 1'b1; // [R10]
        end
    end

    assign cause[W_OVERLOAD] = i_load_factor_pct >= LOAD_WARN_PCT; // [R05]
    assign cause[W_REGEN] = i_regen_factor_pct >= LOAD_WARN_PCT; // [R06]
    assign cause[W_BATTERY] = i_battery_mv <= BATT_WARN_MV; // [R07]
    assign cause[W_FAN] = fan_done; // [R08]
    assign cause[W_ENC_COMM] = over_limit(enc_errs, i_enc_err_limit); // [R09]
    assign cause[W_ENC_HEAT] = i_enc_overheat; // [R11]
    assign cause[W_OSC] = i_vibration > i_oscillation_detect_level; // [R13]
    assign cause[W_LIFE] = i_life_expired; // [R14]
    assign cause[W_SCALE_ALM] = i_scale_alarm; // [R12]
    assign cause[W_SCALE_COMM] = over_limit(scale_errs, i_scale_err_limit); // [R10]

    // One slot per source, each with its own timer
    genvar g;
    generate
        for (g = 0; g < NUM_WARN; g++) begin : slot
            swpm_warn_if wif ();
            assign wif.cause = cause[g];
            assign wif.forever_hold = (g == W_BATTERY) || (g == W_LIFE); // [R03]
            assign wif.latchable = !((g == W_BATTERY) || (g == W_LIFE));
            assign active[g] = wif.active;
            swpm_warn_latch u_latch ( // [R23]
                .i_sys_clk(i_sys_clk),
                .i_sys_rst(i_sys_rst),
                .i_sec_tick(sec_tick),
                .i_alarm_clear_input(i_alarm_clear_input),
                .i_warning_latch_time(i_warning_latch_time),
                .warn(wif.latch)
            );
        end
    endgenerate

    // Over-speed: zero setting selects the 1.2 x max speed default
    wire [19:0] speed_default = 20'(({4'h0, i_motor_max_speed} * 20'(OVERSPEED_NUM)) / 20'(OVERSPEED_DEN));
    wire [19:0] speed_limit = (i_overspeed_level == 16'h0000) ? speed_default : {4'h0, i_overspeed_level};
    wire overspeed = {4'h0, i_motor_speed} > speed_limit; // [R15]

    wire pos_mode = i_ctrl_mode == CTRL_POSITION || i_ctrl_mode == CTRL_FULL_CLOSED;
    // Encoder-unit deviation is taken after the command filters, so they do not count
    wire [31:0] dev_sel = i_deviation_unit_select ? i_dev_enc_unit : i_dev_cmd_unit; // [R18] [R19]
    // Zero setting selects the power-on default level
    wire [31:0] dev_lim = (i_deviation_excess_level == 32'h0) ? DEV_EXCESS_INIT : i_deviation_excess_level; // [R17]
    wire dev_excess = pos_mode && dev_sel > dev_lim; // [R16]
    wire range_excess = pos_mode && i_servo_on && i_motor_pos_abs > i_working_range_setting; // [R20]
    wire [31:0] hyb_lim = (i_hybrid_deviation_level == 32'h0) ? HYBRID_DEV_INIT : i_hybrid_deviation_level;
    wire hyb_excess = i_ctrl_mode == CTRL_FULL_CLOSED && i_hybrid_dev > hyb_lim; // [R21]

    // Trips stay set until the host clears them; a new cause wins over clear
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_trip_overspeed <= 1'b0;
            o_trip_deviation <= 1'b0;
            o_trip_range <= 1'b0;
            o_trip_hybrid <= 1'b0;
        end else begin
            o_trip_overspeed <= overspeed || (o_trip_overspeed && !i_alarm_clear_input); // [R15]
            o_trip_deviation <= dev_excess || (o_trip_deviation && !i_alarm_clear_input); // [R16]
            o_trip_range <= range_excess || (o_trip_range && !i_alarm_clear_input); // [R20]
            o_trip_hybrid <= hyb_excess || (o_trip_hybrid && !i_alarm_clear_input); // [R21]
        end
    end

    wire clamp = i_torque_request > i_first_torque_limit;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_torque_cmd <= 16'h0000;
            o_torque_limiting_output <= 1'b0;
            o_warnings <= '0;
        end else begin
            o_torque_cmd <= clamp ? i_first_torque_limit : i_torque_request; // [R22]
            o_torque_limiting_output <= clamp; // [R22]
            o_warnings <= active; // [R01]
        end
    end

    AST_OVERLOAD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R05]
        (i_load_factor_pct >= LOAD_WARN_PCT && !i_alarm_clear_input) |=> o_warnings[W_OVERLOAD])
        else $error("overload warning missing");
    AST_BATTERY: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R07]
        (i_battery_mv <= BATT_WARN_MV && !i_alarm_clear_input) |=> o_warnings[W_BATTERY])
        else $error("battery warning missing");
    AST_CLEAR_ALL: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R04]
        i_alarm_clear_input |=> o_warnings == '0) else $error("warnings not cleared");
    AST_OVERSPEED: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R15]
        overspeed |=> o_trip_overspeed) else $error("over-speed trip missing");
    // Outside position modes a clear deviation trip must stay clear
    AST_DEV_MODE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R16]
        (!pos_mode && !o_trip_deviation) |=> !o_trip_deviation)
        else $error("deviation trip outside position modes");
    AST_HYBRID: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R21]
        (i_ctrl_mode == CTRL_FULL_CLOSED && i_hybrid_dev > hyb_lim) |=> o_trip_hybrid)
        else $error("hybrid trip missing");
    AST_TORQUE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R22]
        clamp |=> (o_torque_limiting_output && o_torque_cmd == $past(i_first_torque_limit)))
        else $error("torque not clamped");
    AST_FAN_DELAY: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R08]
        $rose(fan_fault) |-> !cause[W_FAN]) else $error("fan warning too early");
    AST_RANGE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R20]
        range_excess |=> o_trip_range) else $error("range trip missing");

    COV_OVERLOAD: cover property (@(posedge i_sys_clk) $rose(o_warnings[W_OVERLOAD]));
    COV_FAN: cover property (@(posedge i_sys_clk) $rose(o_warnings[W_FAN]));
    COV_DEV: cover property (@(posedge i_sys_clk) $rose(o_trip_deviation));
    COV_CLEAR: cover property (@(posedge i_sys_clk) o_warnings[W_BATTERY] ##1 i_alarm_clear_input);
endmodule
`default_nettype wire

// *** swpm_pkg.sv ***
// Purpose: shared constants and types for the servo warning and protection monitor
// Assumes: 10 MHz system clock
// Notes: warning slot order is A0..A9
package swpm_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int NUM_WARN = 10;
    localparam int W_OVERLOAD = 0;
    localparam int W_REGEN = 1;
    localparam int W_BATTERY = 2;
    localparam int W_FAN = 3;
    localparam int W_ENC_COMM = 4;
    localparam int W_ENC_HEAT = 5;
    localparam int W_OSC = 6;
    localparam int W_LIFE = 7;
    localparam int W_SCALE_ALM = 8;
    localparam int W_SCALE_COMM = 9;
    // Warning threshold, percent of protection level
    localparam logic [7:0] LOAD_WARN_PCT = 8'h55;
    // Battery threshold in millivolts (3.2 V)
    localparam logic [15:0] BATT_WARN_MV = 16'h0C80;
    localparam int FAN_STOP_MS = 1000;
    localparam int FAN_STOP_CYC = FAN_STOP_MS * (CLK_HZ / 1000);
    localparam int TICK_MS = 1000;
    localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
    // Latch time codes: 0 none, 1..10 seconds, 15 unlimited
    localparam logic [3:0] LATCH_NONE = 4'h0;
    localparam logic [3:0] LATCH_MAX_S = 4'hA;
    localparam logic [3:0] LATCH_FOREVER = 4'hF;
    localparam logic [31:0] DEV_EXCESS_DEFAULT = 32'h000186A0;
    localparam logic [31:0] HYBRID_DEV_DEFAULT = 32'h00003E80;
    // Over-speed default is 1.2 x max speed, as 12/10
    localparam int OVERSPEED_NUM = 12;
    localparam int OVERSPEED_DEN = 10;
    typedef enum logic [1:0] {CTRL_POSITION, CTRL_VELOCITY, CTRL_TORQUE, CTRL_FULL_CLOSED} ctrl_mode_type;
endpackage

// *** swpm_warn_if.sv ***
// Purpose: carries one warning slot between the monitor and its latch
// Assumes: single clock domain
// Notes: one instance per warning source
`timescale 1ns/100ps
`default_nettype none
interface swpm_warn_if;
    logic cause;
    logic latchable;
    logic forever_hold;
    logic active;
    modport monitor (output cause, output latchable, output forever_hold, input active);
    modport latch (input cause, input latchable, input forever_hold, output active);
endinterface
`default_nettype wire

// *** swpm_warn_latch.sv ***
// Purpose: one warning slot with cause-follow and timed or unlimited hold
// Assumes: i_sec_tick is a one-cycle pulse once per second
// Notes: alarm clear dominates the cause while held
`timescale 1ns/100ps
`default_nettype none
module swpm_warn_latch
    import swpm_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_sec_tick,
    input wire logic i_alarm_clear_input,
    input wire logic [3:0] i_warning_latch_time,
    swpm_warn_if.latch warn
);
    logic held;
    logic [3:0] secs_left;
    wire timed_mode = warn.latchable && i_warning_latch_time != LATCH_NONE;
    wire unlimited = warn.forever_hold || (warn.latchable && i_warning_latch_time == LATCH_FOREVER);
    wire [3:0] load_secs = (i_warning_latch_time > LATCH_MAX_S) ? LATCH_MAX_S : i_warning_latch_time;
    wire expire = !unlimited && i_sec_tick && secs_left <= 4'h1;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_alarm_clear_input) begin // [R04]
            held <= 1'b0;
            secs_left <= 4'h0;
        end else if (warn.cause) begin
            held <= timed_mode || warn.forever_hold; // [R02] [R03]
            secs_left <= load_secs;
        end else if (held) begin
            if (expire) begin
                held <= 1'b0;
            end else if (i_sec_tick && !unlimited) begin
                secs_left <= secs_left - 4'h1;
            end
        end
    end
    // Non-latching slots follow the cause directly [R01]
    assign warn.active = !i_alarm_clear_input && (warn.cause || held);

    AST_CLEAR_WINS: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R04]
        i_alarm_clear_input |-> !warn.active) else $error("warning shown during alarm clear");
    AST_FOREVER_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R03]
        (warn.forever_hold && held && !i_alarm_clear_input) |=> held) else $error("unlimited warning dropped");
    // With no latch time a live cause must never arm the hold of a slot without forever hold
    AST_NOLATCH: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R01]
        (!warn.forever_hold && i_warning_latch_time == LATCH_NONE && warn.cause) |=> !held)
        else $error("non-latching warning held");
    AST_TIMED_RELEASE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R02]
        (held && expire && !warn.cause && !i_alarm_clear_input) |=> !held)
        else $error("timed hold did not release");
endmodule
`default_nettype wire

// *** swpm_host_model.sv ***
// Purpose: host controller model that drives the alarm clear input
// Assumes: one clock; the bench asks for a clear of a given length
// Notes: clear is a level held for the requested number of cycles
`timescale 1ns/100ps
`default_nettype none
module swpm_host_model (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [7:0] i_hold_cycles,
    output logic o_alarm_clear_input
);
    logic [7:0] left;
    // A level, not a pulse, so latched warnings stay cleared while held
    assign o_alarm_clear_input = (left != 8'h00);
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            left <= 8'h00;
        end else if (i_start) begin
            left <= i_hold_cycles;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** servo_warning_protection_monitor_tb.sv ***
// Purpose: self-checking bench for the warning and protection monitor
// Assumes: short second and fan-stop counts set through parameters
// Notes: inputs change by non-blocking assignment at the rising edge
`timescale 1ns/100ps
`default_nettype none
module servo_warning_protection_monitor_tb;
    import swpm_pkg::*;
    logic clk, rst, servo, fan_stop, fan_off, enc_err, enc_ok, sc_err, sc_ok, heat, sc_alm, life, sel, clr_go;
    logic [3:0] latch;
    ctrl_mode_type mode;
    logic [7:0] load, regen, enc_lim, sc_lim;
    logic [15:0] batt, vib, osc, spd, vmax, ospd, treq, tlim;
    logic [31:0] dcmd, denc, dlvl, pos, range, hyb, hlvl;
    logic [9:0] warn;
    logic tr_os, tr_dev, tr_rng, tr_hyb, torque_limiting_output, clr;
    logic [15:0] tcmd;
    int bad_count, checks_done;

    swpm_monitor #(.FAN_STOP_CYCLES(5), .SEC_CYCLES(10)) swpm_monitor_inst (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_alarm_clear_input(clr), .i_warning_latch_time(latch),
        .i_servo_on(servo), .i_ctrl_mode(mode), .i_load_factor_pct(load), .i_regen_factor_pct(regen),
        .i_battery_mv(batt), .i_fan_stopped(fan_stop), .i_fan_servo_off_stop(fan_off),
        .i_enc_comm_err(enc_err), .i_enc_comm_ok(enc_ok), .i_enc_err_limit(enc_lim),
        .i_scale_comm_err(sc_err), .i_scale_comm_ok(sc_ok), .i_scale_err_limit(sc_lim),
        .i_enc_overheat(heat), .i_scale_alarm(sc_alm), .i_vibration(vib), .i_oscillation_detect_level(osc),
        .i_life_expired(life), .i_motor_speed(spd), .i_motor_max_speed(vmax), .i_overspeed_level(ospd),
        .i_dev_cmd_unit(dcmd), .i_dev_enc_unit(denc), .i_deviation_unit_select(sel),
        .i_deviation_excess_level(dlvl), .i_motor_pos_abs(pos), .i_working_range_setting(range),
        .i_hybrid_dev(hyb), .i_hybrid_deviation_level(hlvl), .i_torque_request(treq),
        .i_first_torque_limit(tlim), .o_warnings(warn), .o_trip_overspeed(tr_os), .o_trip_deviation(tr_dev),
        .o_trip_range(tr_rng), .o_trip_hybrid(tr_hyb), .o_torque_cmd(tcmd), .o_torque_limiting_output(torque_limiting_output)
    );
    swpm_host_model swpm_host_model_inst (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_start(clr_go), .i_hold_cycles(8'h06), .o_alarm_clear_input(clr)
    );

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // Ends 1 ns past the edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic clear();
        @(posedge clk);
        clr_go <= 1'b1;
        @(posedge clk);
        clr_go <= 1'b0;
        step(3);
        chk(16'(warn), 16'h0000, "warnings while clear held");
        step(6);
    endtask
    task automatic errs(input bit scale, input int n);
        repeat (n) begin
            @(posedge clk);
            if (scale) begin
                sc_err <= 1'b1;
            end else begin
                enc_err <= 1'b1;
            end
            @(posedge clk);
            {sc_err, enc_err} <= 2'b00;
        end
        step(2);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3_000_000;
        bad_count++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        {servo, fan_stop, fan_off, enc_err, enc_ok, sc_err, sc_ok, heat, sc_alm, life, sel, clr_go} = '0;
        {latch, load, regen, vib, osc, spd, vmax, ospd, treq, dcmd, denc, dlvl, pos, range, hyb, hlvl} = '0;
        {enc_lim, sc_lim} = {8'h02, 8'h02};
        mode = CTRL_POSITION;
        batt = 16'h1000;
        tlim = 16'hFFFF;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        step(2);
        chk({6'h00, warn}, 16'h0000, "warnings after reset");
        chk({tr_os, tr_dev, tr_rng, tr_hyb, torque_limiting_output}, 16'h0000, "trips after reset");
        @(posedge clk);
        {load, regen, batt} <= {8'h54, 8'h54, 16'h0C81};
        step(3);
        chk(16'(warn), 16'h0000, "just below thresholds");
        @(posedge clk);
        load <= 8'h55;
        step(2);
        chk(16'(warn), 16'h0001, "overload");
        @(posedge clk);
        {load, regen} <= {8'h00, 8'h55};
        step(2);
        chk(16'(warn), 16'h0002, "overload gone, regen");
        @(posedge clk);
        {regen, batt, life} <= {8'h00, 16'h0C80, 1'b1};
        step(2);
        @(posedge clk);
        {batt, life} <= {16'h1000, 1'b0};
        step(30);
        chk(16'(warn), 16'h0084, "battery and life held");
        clear();
        chk(16'(warn), 16'h0000, "after clear");
        @(posedge clk);
        fan_stop <= 1'b1;
        step(4);
        chk(16'(warn), 16'h0000, "fan not yet");
        step(5);
        chk(16'(warn), 16'h0008, "fan stopped");
        @(posedge clk);
        fan_stop <= 1'b0;
        step(2);
        @(posedge clk);
        {fan_stop, fan_off} <= 2'b11;
        step(12);
        chk(16'(warn), 16'h0000, "deliberate stop at servo off");
        @(posedge clk);
        {fan_stop, fan_off} <= 2'b00;
        errs(1'b0, 2);
        errs(1'b1, 2);
        chk(16'(warn), 16'h0000, "errors at the limit");
        errs(1'b0, 1);
        chk(16'(warn), 16'h0010, "encoder errors");
        errs(1'b1, 1);
        chk(16'(warn), 16'h0210, "scale errors");
        @(posedge clk);
        {enc_ok, sc_ok} <= 2'b11;
        @(posedge clk);
        {enc_ok, sc_ok} <= 2'b00;
        step(2);
        chk(16'(warn), 16'h0000, "good frames reset counts");
        @(posedge clk);
        {heat, sc_alm, osc, vib} <= {2'b11, 16'h0100, 16'h0100};
        step(2);
        chk(16'(warn), 16'h0120, "overheat and scale alarm");
        @(posedge clk);
        vib <= 16'h0101;
        step(2);
        chk(16'(warn), 16'h0160, "oscillation");
        @(posedge clk);
        {heat, sc_alm, vib, latch, load} <= {2'b00, 16'h0000, 4'h2, 8'h55};
        step(2);
        @(posedge clk);
        heat <= 1'b1;
        step(2);
        @(posedge clk);
        heat <= 1'b0;
        step(6);
        chk(16'(warn), 16'h0021, "overheat held");
        step(20);
        @(posedge clk);
        load <= 8'h00;
        step(5);
        chk(16'(warn), 16'h0001, "independent hold");
        step(20);
        chk(16'(warn), 16'h0000, "holds expired");
        @(posedge clk);
        {latch, heat} <= {4'hF, 1'b1};
        step(2);
        @(posedge clk);
        heat <= 1'b0;
        step(40);
        chk(16'(warn), 16'h0020, "unlimited hold");
        clear();
        @(posedge clk);
        {latch, vmax, spd} <= {4'h0, 16'h03E8, 16'h04B0};
        step(3);
        chk(16'(tr_os), 16'h0000, "speed at 1.2 x max");
        @(posedge clk);
        spd <= 16'h04B1;
        step(2);
        chk(16'(tr_os), 16'h0001, "over-speed");
        @(posedge clk);
        spd <= 16'h0000;
        dcmd <= 32'h000186A0;
        clear();
        chk({tr_os, tr_dev}, 16'h0000, "trip cleared, deviation at default");
        @(posedge clk);
        dcmd <= 32'h000186A1;
        step(2);
        chk(16'(tr_dev), 16'h0001, "command deviation");
        @(posedge clk);
        {dcmd, sel, denc} <= {32'h00030000, 1'b1, 32'h000186A0};
        clear();
        chk(16'(tr_dev), 16'h0000, "encoder units selected");
        @(posedge clk);
        denc <= 32'h000186A1;
        step(2);
        chk(16'(tr_dev), 16'h0001, "encoder deviation");
        @(posedge clk);
        mode <= CTRL_VELOCITY;
        {servo, range, pos} <= {1'b1, 32'h00000064, 32'h00000065};
        clear();
        chk({tr_dev, tr_rng}, 16'h0000, "velocity mode refuses");
        @(posedge clk);
        mode <= CTRL_POSITION;
        step(2);
        chk(16'(tr_rng), 16'h0001, "working range");
        @(posedge clk);
        {pos, denc, hyb} <= {32'h0, 32'h0, 32'h00003E80};
        mode <= CTRL_FULL_CLOSED;
        clear();
        chk({tr_rng, tr_hyb}, 16'h0000, "hybrid at default");
        @(posedge clk);
        hyb <= 32'h00003E81;
        step(2);
        chk(16'(tr_hyb), 16'h0001, "hybrid deviation");
        @(posedge clk);
        {treq, tlim} <= {16'h01F4, 16'h012C};
        step(2);
        chk({torque_limiting_output, tcmd[14:0]}, 16'h812C, "torque clamped");
        @(posedge clk);
        treq <= 16'h00C8;
        step(2);
        chk({torque_limiting_output, tcmd[14:0]}, 16'h00C8, "torque passed");
        end_of_test();
    end
endmodule
`default_nettype wire
